// >>> src/ltb_pkg.sv
package ltb_pkg;
	// Register byte offsets
	localparam logic [7:0] ltb_ctrl_off = 8'h00;
	localparam logic [7:0] ltb_pat_off = 8'h04;
	localparam logic [7:0] ltb_width_off = 8'h08;
	localparam logic [7:0] ltb_w_up_off = 8'h0c;
	localparam logic [7:0] ltb_w_lo_off = 8'h10;
	localparam logic [7:0] ltb_n_up_off = 8'h14;
	localparam logic [7:0] ltb_n_lo_off = 8'h18;
	localparam logic [7:0] ltb_value_off = 8'h1c;
	localparam logic [7:0] ltb_status_off = 8'h20;
	localparam logic [7:0] ltb_cmd_off = 8'h24;
	// Control fields
	localparam int ltb_ctl_wide_en = 0;
	localparam int ltb_ctl_narrow_en = 1;
	localparam int ltb_ctl_math_en = 2;
	localparam int ltb_ctl_arm_lsb = 3;
	localparam int ltb_ctl_l4_lsb = 5;
	localparam int ltb_ctl_auto_clr = 7;
	localparam int ltb_ctl_init_clr = 8;
	localparam logic [31:0] ltb_ctrl_rst = 32'h0000_0100;
	// Pattern register nibbles
	localparam int ltb_pat_w_up = 0;
	localparam int ltb_pat_w_lo = 4;
	localparam int ltb_pat_n_up = 8;
	localparam int ltb_pat_n_lo = 12;
	localparam int ltb_pat_pass = 16;
	localparam int ltb_pat_clear = 20;
	localparam logic [31:0] ltb_pat_rst = 32'h0000_ffff;
	// Command bits
	localparam int ltb_cmd_start = 0;
	localparam int ltb_cmd_clear = 1;
	localparam int ltb_cmd_init = 2;
	// Timing
	localparam int ltb_clk_mhz = 250;
	localparam int ltb_step_us = 10;
	localparam int ltb_step_cyc = ltb_step_us * ltb_clk_mhz;
	localparam int ltb_skew_us = 10;
	localparam int ltb_extra_us = 20;
	localparam int ltb_width_max = 6000000;
	typedef enum logic [1:0] {
		ltb_arm_immediate = 2'h0,
		ltb_arm_low = 2'h1,
		ltb_arm_high = 2'h2
	} ltb_arm_e;
	typedef enum logic [1:0] {
		ltb_l4_busy = 2'h0,
		ltb_l4_busy_inv = 2'h1,
		ltb_l4_strobe = 2'h2
	} ltb_l4_e;
	typedef enum logic [2:0] {
		ltb_idle = 3'h0,
		ltb_test = 3'h1,
		ltb_settle = 3'h3,
		ltb_pulse = 3'h2,
		ltb_tail = 3'h6,
		ltb_hold = 3'h7
	} ltb_state_e;
endpackage

// >>> src/ltb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Wide band first; fail skips narrow test
// - Narrow test after wide pass; both pass
// - Disabled limit test is skipped entirely
// - Math result compared when math active
// - Five patterns, exactly one per part
// - Four result lines, one start input
// - Low arm event starts on falling edge
// - High arm event starts on rising edge
// - Immediate arm starts on command, needs enable
// - Category register: code, then line 4 strobe
// - Busy mode: line 4 high during test
// - Inverted busy: line 4 low during test
// - Register handler uses finish strobe mode
// - Strobe polarity from clear pattern line 4
// - Auto-clear restores clear pattern after width
// - Busy modes force line 4 clear level
// - Width 0 to 60 s, 10 us steps
// - Lines 1-3 hold 10 us past line 4
// - Line 4 strobe 10 us after code
// - Pattern bit n drives line n+1
// - Initiate returns outputs to clear pattern
module ltb_top #(
	parameter int value_width = 32,
	parameter int step_cycles = ltb_pkg::ltb_step_cyc
) (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Measurement in
	input wire logic [value_width-1:0] raw_value,
	input wire logic [value_width-1:0] math_value,
	input wire logic value_valid,
	// Handler port
	input wire logic start_of_test_line,
	output logic [3:0] handler_out
);
	logic rst_meta, rst_sync_n;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// Start line synchroniser and edge detect
	// Resets high: a low-active idle line gives no edge
	logic sot_meta, sot_sync, sot_prev;
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			sot_meta <= 1'b1;
			sot_sync <= 1'b1;
			sot_prev <= 1'b1;
		end else begin
			sot_meta <= start_of_test_line;
			sot_sync <= sot_meta;
			sot_prev <= sot_sync;
		end
	end

	logic [31:0] ctrl, pats, width, w_up, w_lo, n_up, n_lo;
	logic [31:0] last_value;
	logic [3:0] result_code;
	logic wide_fail, narrow_fail, busy_flag;
	ltb_pkg::ltb_state_e state, next_state;

	wire ltb_pkg::ltb_arm_e arm_mode =
		ltb_pkg::ltb_arm_e'(ctrl[ltb_pkg::ltb_ctl_arm_lsb +: 2]);
	wire ltb_pkg::ltb_l4_e l4_mode =
		ltb_pkg::ltb_l4_e'(ctrl[ltb_pkg::ltb_ctl_l4_lsb +: 2]);
	wire wide_en = ctrl[ltb_pkg::ltb_ctl_wide_en];
	wire narrow_en = ctrl[ltb_pkg::ltb_ctl_narrow_en];
	wire auto_clr = ctrl[ltb_pkg::ltb_ctl_auto_clr];
	wire init_clr = ctrl[ltb_pkg::ltb_ctl_init_clr];
	wire [3:0] clear_pat = pats[ltb_pkg::ltb_pat_clear +: 4];

	// APB decode; zero wait states
	wire wr = psel && penable && pwrite;
	wire cmd_wr = wr && paddr == ltb_pkg::ltb_cmd_off;
	wire cmd_start = cmd_wr && pwdata[ltb_pkg::ltb_cmd_start];
	wire cmd_clear = cmd_wr && pwdata[ltb_pkg::ltb_cmd_clear];
	wire cmd_init = cmd_wr && pwdata[ltb_pkg::ltb_cmd_init];
	wire mapped = paddr[1:0] == 2'h0 && paddr <= ltb_pkg::ltb_cmd_off;

	// Arm events
	wire any_en = wide_en || narrow_en;
	wire sot_fall = sot_prev && !sot_sync;
	wire sot_rise = !sot_prev && sot_sync;
	logic arm_hit;
	always_comb begin
		case (arm_mode)
			ltb_pkg::ltb_arm_low: arm_hit = sot_fall;
			ltb_pkg::ltb_arm_high: arm_hit = sot_rise;
			ltb_pkg::ltb_arm_immediate: arm_hit = cmd_start;
			default: arm_hit = 1'b0;
		endcase
	end
	// Arm events outside idle are dropped, not queued
	wire start_go = state == ltb_pkg::ltb_idle && arm_hit && any_en;

	// Limit comparison, signed, inclusive band
	function automatic logic [1:0] band_check(
		input logic [value_width-1:0] v,
		input logic [value_width-1:0] up,
		input logic [value_width-1:0] lo
	);
		band_check = {$signed(v) < $signed(lo),
			$signed(v) > $signed(up)};
	endfunction

	wire [value_width-1:0] test_value =
		ctrl[ltb_pkg::ltb_ctl_math_en] ? math_value : raw_value;
	wire [1:0] wide_res = band_check(test_value,
		w_up[value_width-1:0], w_lo[value_width-1:0]);
	wire [1:0] narrow_res = band_check(test_value,
		n_up[value_width-1:0], n_lo[value_width-1:0]);
	wire wide_bad = wide_en && wide_res != 2'h0;
	wire narrow_bad = narrow_en && narrow_res != 2'h0;

	// One of five patterns per part
	logic [3:0] next_code;
	always_comb begin
		if (wide_bad) begin
			next_code = wide_res[0] ? pats[ltb_pkg::ltb_pat_w_up +: 4]
				: pats[ltb_pkg::ltb_pat_w_lo +: 4];
		end else if (narrow_bad) begin
			next_code = narrow_res[0] ? pats[ltb_pkg::ltb_pat_n_up +: 4]
				: pats[ltb_pkg::ltb_pat_n_lo +: 4];
		end else begin
			next_code = pats[ltb_pkg::ltb_pat_pass +: 4];
		end
	end

	// 10 us tick divider, restarted with each result phase
	logic [$clog2(step_cycles+1)-1:0] div_cnt;
	logic [22:0] step_cnt;
	wire tick = div_cnt == ($bits(div_cnt))'(step_cycles - 1);
	wire [22:0] pulse_steps = width[22:0] > 23'(ltb_pkg::ltb_width_max)
		? 23'(ltb_pkg::ltb_width_max) : width[22:0];
	localparam logic [22:0] skew_steps =
		23'(ltb_pkg::ltb_skew_us / ltb_pkg::ltb_step_us);
	localparam logic [22:0] tail_steps = 23'((ltb_pkg::ltb_extra_us
		- ltb_pkg::ltb_skew_us) / ltb_pkg::ltb_step_us);
	wire step_done = tick && step_cnt == 23'h0;

	always_comb begin
		next_state = state;
		case (state)
			ltb_pkg::ltb_idle: if (start_go) next_state = ltb_pkg::ltb_test;
			ltb_pkg::ltb_test: if (value_valid) next_state = ltb_pkg::ltb_settle;
			ltb_pkg::ltb_settle: begin
				if (step_done) begin
					next_state = pulse_steps == 23'h0 ? ltb_pkg::ltb_tail
						: ltb_pkg::ltb_pulse;
				end
			end
			ltb_pkg::ltb_pulse: if (step_done) next_state = ltb_pkg::ltb_tail;
			ltb_pkg::ltb_tail: begin
				if (step_done) begin
					next_state = auto_clr ? ltb_pkg::ltb_idle
						: ltb_pkg::ltb_hold;
				end
			end
			// Clear only counts once the result is held
			ltb_pkg::ltb_hold: if (cmd_clear) next_state = ltb_pkg::ltb_idle;
			default: next_state = ltb_pkg::ltb_idle;
		endcase
		// Initiate with clear enabled drops any result
		if (cmd_init && init_clr) begin
			next_state = ltb_pkg::ltb_idle;
		end
	end

	wire phase_change = state != next_state;

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			div_cnt <= '0;
			step_cnt <= 23'h0;
		end else if (phase_change) begin
			div_cnt <= '0;
			case (next_state)
				ltb_pkg::ltb_settle: step_cnt <= skew_steps - 23'h1;
				ltb_pkg::ltb_pulse: step_cnt <= pulse_steps - 23'h1;
				default: step_cnt <= tail_steps - 23'h1;
			endcase
		end else if (tick) begin
			div_cnt <= '0;
			step_cnt <= step_cnt - 23'h1;
		end else begin
			div_cnt <= div_cnt + 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state <= ltb_pkg::ltb_idle;
			result_code <= 4'h0;
			wide_fail <= 1'b0;
			narrow_fail <= 1'b0;
			last_value <= 32'h0;
		end else begin
			state <= next_state;
			if (state == ltb_pkg::ltb_test && value_valid) begin
				result_code <= next_code;
				wide_fail <= wide_bad;
				narrow_fail <= !wide_bad && narrow_bad;
				last_value <= 32'(test_value);
			end
		end
	end

	// Output drive; line n is bit n-1
	wire showing = state == ltb_pkg::ltb_settle
		|| state == ltb_pkg::ltb_pulse || state == ltb_pkg::ltb_tail
		|| state == ltb_pkg::ltb_hold;
	wire testing = state == ltb_pkg::ltb_test;
	logic [3:0] next_out;
	logic line4_clear, line4_result;
	always_comb begin
		case (l4_mode)
			ltb_pkg::ltb_l4_busy: line4_clear = 1'b0;
			ltb_pkg::ltb_l4_busy_inv: line4_clear = 1'b1;
			default: line4_clear = clear_pat[3];
		endcase
		if (l4_mode == ltb_pkg::ltb_l4_strobe) begin
			// Strobe level opposite to rest; code bit 3 ignored
			// Rests again from tail on, so the handler latches once
			line4_result = state == ltb_pkg::ltb_pulse
				? !clear_pat[3] : clear_pat[3];
		end else if (testing) begin
			line4_result = !line4_clear;
		end else begin
			line4_result = showing ? result_code[3] : line4_clear;
		end
		if (showing) begin
			next_out = {line4_result, result_code[2:0]};
		end else begin
			next_out = {line4_result, clear_pat[2:0]};
		end
	end

	// All lines low in reset; clear pattern a cycle later
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			handler_out <= 4'h0;
		end else begin
			handler_out <= next_out;
		end
	end

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			busy_flag <= 1'b0;
		end else begin
			busy_flag <= state != ltb_pkg::ltb_idle;
		end
	end

	// Register writes; unused upper bits of control, pattern and width stored as zero
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ctrl <= ltb_pkg::ltb_ctrl_rst;
			pats <= ltb_pkg::ltb_pat_rst;
			width <= 32'h0;
			w_up <= 32'h0;
			w_lo <= 32'h0;
			n_up <= 32'h0;
			n_lo <= 32'h0;
		end else if (wr) begin
			case (paddr)
				ltb_pkg::ltb_ctrl_off: ctrl <= {23'h0, pwdata[8:0]};
				ltb_pkg::ltb_pat_off: pats <= {8'h0, pwdata[23:0]};
				ltb_pkg::ltb_width_off: width <= {9'h0, pwdata[22:0]};
				ltb_pkg::ltb_w_up_off: w_up <= pwdata;
				ltb_pkg::ltb_w_lo_off: w_lo <= pwdata;
				ltb_pkg::ltb_n_up_off: n_up <= pwdata;
				ltb_pkg::ltb_n_lo_off: n_lo <= pwdata;
				default: ;
			endcase
		end
	end

	// Initiate flag for status; the clear is done by the state machine
	logic init_pending;
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			init_pending <= 1'b0;
		end else begin
			init_pending <= cmd_init && init_clr;
		end
	end

	// Status bits for software polling
	wire [31:0] status_word = {26'h0, init_pending, narrow_fail,
		wide_fail, showing, testing, busy_flag};
	logic [31:0] next_rdata;
	always_comb begin
		case (paddr)
			ltb_pkg::ltb_ctrl_off: next_rdata = ctrl;
			ltb_pkg::ltb_pat_off: next_rdata = pats;
			ltb_pkg::ltb_width_off: next_rdata = width;
			ltb_pkg::ltb_w_up_off: next_rdata = w_up;
			ltb_pkg::ltb_w_lo_off: next_rdata = w_lo;
			ltb_pkg::ltb_n_up_off: next_rdata = n_up;
			ltb_pkg::ltb_n_lo_off: next_rdata = n_lo;
			ltb_pkg::ltb_value_off: next_rdata = last_value;
			ltb_pkg::ltb_status_off: next_rdata = status_word;
			default: next_rdata = 32'h0;
		endcase
	end

	// Registered answer; pready rises in the first access cycle
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata <= psel && !penable ? next_rdata : 32'h0;
		end
	end
endmodule
`default_nettype wire

// >>> tb/ltb_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ltb_checker (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Handler port
	input wire logic [3:0] handler_out
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	logic strobe_mode;
	wire acc = psel && penable && pready;
	wire bad = paddr > 8'h24 || paddr[1:0] != 2'h0;
	// Shadow of the line 4 mode, from control writes
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			strobe_mode <= 1'b0;
		else if (acc && pwrite && paddr == 8'h00)
			strobe_mode <= pwdata[6:5] == 2'h2;
	end
	a_ready_setup: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_err_bad: assert property (acc && bad |-> pslverr)
		else $error("bad address accepted");
	a_err_good: assert property (acc && !bad |-> !pslverr)
		else $error("good address refused");
	a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read not zero");
	a_reset_quiet: assert property (disable iff (1'b0)
		!arst_n |-> handler_out == 4'h0 && !pready)
		else $error("outputs active in reset");
	a_code_settles: assert property (
		strobe_mode && $changed(handler_out[3])
		|-> $past(handler_out[2:0], 3) == handler_out[2:0])
		else $error("strobe moved before code settled");
	a_code_outlasts: assert property (
		strobe_mode && $changed(handler_out[3])
		|=> $stable(handler_out[2:0])[*3])
		else $error("code dropped too soon after strobe");
endmodule
bind ltb_top ltb_checker ltb_checker_i (.clock, .arst_n, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .handler_out);
`default_nettype wire

// >>> tb/ltb_handler.sv
`timescale 1ns/1ps
`default_nettype none
module ltb_handler (
	// Control from bench
	input wire logic low_active,
	input wire logic go,
	input wire logic clock,
	// Device port
	input wire logic [3:0] handler_out,
	output logic start_of_test_line,
	output logic [2:0] bin_code
);
	// Idle level until a part is seated
	assign start_of_test_line = go ? !low_active : low_active;
	// High-going strobe only; the bench keeps a low rest in strobe mode
	always_ff @(posedge clock)
		if (handler_out[3])
			bin_code <= handler_out[2:0];
endmodule
`default_nettype wire

// >>> tb/limit_test_binning_io_test.sv
`timescale 1ns/1ps
`default_nettype none
module limit_test_binning_io_test;
	typedef struct packed {
		logic [2:0] ctl;
		logic [31:0] raw;
		logic [31:0] mth;
		logic [2:0] code;
	} ltb_row_s;
	localparam int sc = 4;
	localparam int wd = 2;
	logic clock = 1'b0;
	logic arst_n;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] raw_value = 32'h0;
	logic [31:0] math_value = 32'h0;
	logic value_valid = 1'b0;
	logic low_active = 1'b0;
	logic go = 1'b0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er, start_of_test_line;
	logic [3:0] handler_out;
	logic [2:0] bin_code;
	int errors = 0;
	int checked = 0;
	int c;
	ltb_row_s rows [10] = '{
		'{3'h3, 32'h0, 32'h0, 3'h5},
		'{3'h1, 32'h64, 32'h0, 3'h5},
		'{3'h1, 32'hffff_ff9c, 32'h0, 3'h5},
		'{3'h3, 32'h65, 32'h0, 3'h1},
		'{3'h3, 32'hffff_ff9b, 32'h0, 3'h2},
		'{3'h3, 32'h32, 32'h0, 3'h3},
		'{3'h3, 32'hffff_fff5, 32'h0, 3'h4},
		'{3'h1, 32'h32, 32'h0, 3'h5},
		'{3'h2, 32'hc8, 32'h0, 3'h3},
		'{3'h7, 32'h0, 32'hc8, 3'h1}};
	always #2 clock = ~clock;
	ltb_top #(.value_width(32), .step_cycles(sc)) ltb_top_i (.clock, .arst_n,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.raw_value, .math_value, .value_valid, .start_of_test_line,
		.handler_out);
	ltb_handler ltb_handler_i (.low_active, .go, .clock, .handler_out,
		.start_of_test_line, .bin_code);
	task automatic results;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic fail(input string m);
		errors++;
		$display("[FAIL] %0t %s", $time, m);
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e)
			fail($sformatf("got %h want %h", g, e));
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge clock);
			if (pready === 1'b1)
				break;
		end
		if (n == 20)
			fail("bus timeout");
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic until_out(input logic [3:0] m, input logic [3:0] v);
		for (c = 1; c < 300; c++) begin
			@(posedge clock);
			if ((handler_out & m) === v)
				break;
		end
		if (c == 300)
			fail("handler timeout");
	endtask
	task automatic idle_chk(input logic [3:0] v);
		repeat (12) @(posedge clock);
		chk(handler_out, v);
	endtask
	task automatic part(input logic [2:0] code);
		until_out(4'h7, {1'b0, code});
		chk(handler_out, {1'b0, code});
		until_out(4'hf, {1'b1, code});
		chk(c, sc);
		until_out(4'hf, {1'b0, code});
		chk(c, wd * sc);
		until_out(4'h7, 4'h0);
		chk(c, sc);
		chk(bin_code, code);
	endtask
	initial begin
		#40000;
		fail("watchdog");
		results();
	end
	initial begin
		arst_n <= 1'b0;
		repeat (12) @(posedge clock);
		arst_n <= 1'b1;
		idle_chk(4'h0);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h100);
		apb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'hffff);
		apb(1'b0, 8'h28, 32'h0);
		chk(er, 1'b1);
		chk(rd, 32'h0);
		apb(1'b1, 8'h04, 32'h0005_4321);
		apb(1'b1, 8'h08, wd);
		apb(1'b1, 8'h0c, 32'h64);
		apb(1'b1, 8'h10, 32'hffff_ff9c);
		apb(1'b1, 8'h14, 32'ha);
		apb(1'b1, 8'h18, 32'hffff_fff6);
		value_valid <= 1'b1;
		foreach (rows[i]) begin
			raw_value <= rows[i].raw;
			math_value <= rows[i].mth;
			apb(1'b1, 8'h00, {23'h0, 9'h1c0 | rows[i].ctl});
			apb(1'b1, 8'h24, 32'h1);
			part(rows[i].code);
		end
		apb(1'b0, 8'h1c, 32'h0);
		chk(rd, 32'hc8);
		raw_value <= 32'h0;
		apb(1'b1, 8'h00, 32'hd1);
		idle_chk(4'h0);
		go <= 1'b1;
		part(3'h5);
		go <= 1'b0;
		apb(1'b1, 8'h00, 32'hc9);
		low_active <= 1'b1;
		idle_chk(4'h0);
		go <= 1'b1;
		part(3'h5);
		go <= 1'b0;
		apb(1'b1, 8'h00, 32'h1c1);
		go <= 1'b1;
		idle_chk(4'h0);
		go <= 1'b0;
		apb(1'b1, 8'h00, 32'h1c0);
		apb(1'b1, 8'h24, 32'h1);
		idle_chk(4'h0);
		apb(1'b1, 8'h04, 32'h0085_4321);
		apb(1'b1, 8'h00, 32'h181);
		value_valid <= 1'b0;
		idle_chk(4'h0);
		apb(1'b1, 8'h24, 32'h1);
		idle_chk(4'h8);
		value_valid <= 1'b1;
		until_out(4'hf, 4'h5);
		until_out(4'hf, 4'h0);
		apb(1'b1, 8'h04, 32'h0005_4321);
		apb(1'b1, 8'h00, 32'h1a1);
		value_valid <= 1'b0;
		idle_chk(4'h8);
		apb(1'b1, 8'h24, 32'h1);
		repeat (12) @(posedge clock);
		chk(handler_out[3], 1'b0);
		value_valid <= 1'b1;
		until_out(4'hf, 4'h8);
		apb(1'b1, 8'h00, 32'h141);
		apb(1'b1, 8'h24, 32'h1);
		until_out(4'h7, 4'h5);
		repeat (12) @(posedge clock);
		idle_chk(4'h5);
		apb(1'b1, 8'h24, 32'h2);
		idle_chk(4'h0);
		apb(1'b1, 8'h24, 32'h1);
		until_out(4'h7, 4'h5);
		repeat (12) @(posedge clock);
		idle_chk(4'h5);
		apb(1'b1, 8'h24, 32'h4);
		idle_chk(4'h0);
		results();
	end
endmodule
`default_nettype wire
